// *** lccdt_pkg.sv ***
// package: register map, field layout and types of the channel divider
package lccdt_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int         ADDR_W    = 12;       // byte address width
  localparam int         DATA_W    = 32;       // bus data width
  localparam int         REG_W     = 8;        // register width
  localparam int         IDX_LSB   = 2;        // word aligned registers
  localparam logic [9:0] IDX_CNT1  = 10'h19e;  // first stage counts
  localparam logic [9:0] IDX_PHASE = 10'h19f;  // phase offsets
  localparam logic [9:0] IDX_CNT2  = 10'h1a0;  // second stage counts
  localparam logic [9:0] IDX_CTRL  = 10'h1a1;  // channel control
  localparam logic [9:0] IDX_DUTY  = 10'h1a2;  // duty correction
  localparam logic [9:0] IDX_STAT  = 10'h1a3;  // live status, read only
  localparam logic [7:0] REG_RST   = 8'h00;    // reset value of all fields

  // ****************************************
  // field layout
  // ****************************************
  localparam int         NIB_W      = 4;       // count and phase width
  localparam int         LOW_LSB    = 4;       // low count nibble
  localparam int         HIGH_LSB   = 0;       // high count nibble
  localparam int         PH2_LSB    = 4;       // second stage phase
  localparam int         PH1_LSB    = 0;       // first stage phase
  localparam int         CTL_BYP2   = 5;       // bypass second stage
  localparam int         CTL_BYP1   = 4;       // bypass first stage
  localparam int         CTL_NOSYNC = 3;       // ignore chip sync
  localparam int         CTL_FORCE  = 2;       // static level select
  localparam int         CTL_START2 = 1;       // second stage starts high
  localparam int         CTL_START1 = 0;       // first stage starts high
  localparam int         DUTY_OFF   = 0;       // duty fix disable
  localparam logic [7:0] CTRL_MASK  = 8'h3f;   // implemented control bits
  localparam logic [7:0] DUTY_MASK  = 8'h01;   // implemented duty bits
  localparam int         ST_SYNC    = 0;       // status: sync held
  localparam int         ST_OUT     = 1;       // status: channel output
  localparam int         ST_S1      = 2;       // status: first stage level
  localparam int         ST_S2      = 3;       // status: second stage level

  // ****************************************
  // bus answers and sizes
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;   // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2;   // unmapped or read only
  localparam logic [2:0] SYNC_IDLE   = 3'h7;   // pin idle level, active low
  localparam int         NUM_STAGES  = 2;      // cascaded stages
  localparam int         CNT_W       = 5;      // stage counter width
  localparam int         PER_W       = 12;     // period counter width

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic [3:0] low_n;       // low phase length minus one
    logic [3:0] high_n;      // high phase length minus one
    logic [3:0] phase;       // input periods waited after sync
    logic       start_high;  // level held during sync
    logic       bypass;      // pass input straight through
  } lccdt_stage_cfg_type;

  typedef struct packed {
    logic tick;   // one cycle pulse at each rising edge
    logic level;  // clock level
  } lccdt_clk_type;

  typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} lccdt_wr_state_type;
  typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} lccdt_rd_state_type;

endpackage

// *** lccdt_divider.sv ***
// one divider stage: high and low counts, phase wait, start level, bypass
`timescale 1ns/100ps

module lccdt_divider
  import lccdt_pkg::*;
(
  // clock and reset
  input  logic                clock,
  input  logic                rst_b,
  // settings and sync hold
  input  lccdt_stage_cfg_type cfg,
  input  logic                hold,
  // divided clock in and out
  input  lccdt_clk_type       clk_in,
  output lccdt_clk_type       clk_out
);

  logic [CNT_W-1:0] cnt_q, cnt_d;      // input periods in this phase
  logic [CNT_W-1:0] wait_q, wait_d;    // phase offset periods left
  logic             level_q, level_d;  // divided level
  logic             rise_q, rise_d;    // rising edge pulse
  logic [CNT_W-1:0] limit;             // last count of this phase
  logic             phase_end;         // phase length reached

  assign limit = level_q ? {1'b0, cfg.high_n} : {1'b0, cfg.low_n}; // R01 R02
  assign phase_end = clk_in.tick && (wait_q == '0) && (cnt_q == limit);

  // next state of the counter
  always_comb begin
    cnt_d   = cnt_q;
    wait_d  = wait_q;
    level_d = level_q;
    rise_d  = 1'b0;
    if (cfg.bypass) begin
      // counting parked while bypassed
      cnt_d   = '0;
      wait_d  = '0;
      level_d = cfg.start_high;
    end else if (hold) begin
      // park at start level, load phase wait
      cnt_d   = '0;
      wait_d  = {1'b0, cfg.phase}; // R13
      level_d = cfg.start_high;    // R09 R10
    end else if (clk_in.tick && (wait_q != '0)) begin
      wait_d = wait_q - 1'b1;      // R13
    end else if (phase_end) begin
      cnt_d   = '0;
      level_d = ~level_q;          // R01 R02
      rise_d  = ~level_q;
    end else if (clk_in.tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // stage registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q   <= '0;
      wait_q  <= '0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      wait_q  <= wait_d;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end

  // bypass routes input to output
  assign clk_out.level = cfg.bypass ? clk_in.level : level_q; // R05 R06
  assign clk_out.tick  = cfg.bypass ? clk_in.tick : rise_q;   // R05 R06

endmodule // lccdt_divider

// *** lccdt_duty_fix.sv ***
// duty corrector: output high for half of each measured period
`timescale 1ns/100ps

module lccdt_duty_fix
  import lccdt_pkg::*;
(
  // clock and reset
  input  logic          clock,
  input  logic          rst_b,
  // control and clock
  input  logic          enable,
  input  lccdt_clk_type clk_in,
  output logic          out_level
);

  logic [PER_W-1:0] cnt_q;    // cycles since last rising edge
  logic [PER_W-1:0] half_q;   // half of last period
  logic [PER_W-1:0] cnt_inc;  // next count
  logic             out_q;    // corrected level
  logic             out_d;

  assign cnt_inc = cnt_q + 1'b1;
  // corrected level or plain pass
  assign out_d = enable ? (clk_in.tick || (cnt_inc < half_q)) : clk_in.level;

  // period measure and output
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q  <= '0;
      half_q <= '0;
      out_q  <= 1'b0;
    end else begin
      out_q <= out_d;
      if (clk_in.tick) begin
        cnt_q  <= '0;
        half_q <= cnt_inc >> 1;
      end else if (cnt_q != '1) begin
        cnt_q <= cnt_inc;
      end
    end
  end

  assign out_level = out_q;

endmodule // lccdt_duty_fix

// *** lccdt_top.sv ***
// top: register slave, sync input and the two stage channel divider
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps

// Overview of operation
// [R01] second stage low lasts count plus one
// [R02] second stage high lasts count plus one
// [R03] first stage has own low/high counts
// [R04] phase offsets: second upper, first lower
// [R05] bypass passes input to second output
// [R06] bypass passes input to first output
// [R07] ignore bit masks chip sync
// [R08] force bit gives static high with ignore
// [R09] second stage start level select
// [R10] first stage start level select
// [R11] duty fix on unless disable bit set
// [R12] first stage output clocks second stage
// [R13] sync holds start level, phase after release
module lccdt_top
  import lccdt_pkg::*;
(
  // clock and reset
  input  logic              clock,
  input  logic              rst_b,
  // write address
  input  logic [ADDR_W-1:0] s_axi_awaddr,
  input  logic [2:0]        s_axi_awprot,
  input  logic              s_axi_awvalid,
  output logic              s_axi_awready,
  // write data
  input  logic [DATA_W-1:0] s_axi_wdata,
  input  logic [3:0]        s_axi_wstrb,
  input  logic              s_axi_wvalid,
  output logic              s_axi_wready,
  // write response
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  logic              s_axi_bready,
  // read address
  input  logic [ADDR_W-1:0] s_axi_araddr,
  input  logic [2:0]        s_axi_arprot,
  input  logic              s_axi_arvalid,
  output logic              s_axi_arready,
  // read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  logic              s_axi_rready,
  // chip sync pin
  input  logic              sync_req_b,
  // divided clocks
  output logic              stage1_out,
  output logic              stage2_out,
  output logic              channel_out
);

  // ****************************************
  // declarations
  // ****************************************
  lccdt_wr_state_type wr_state_q;   // write channel state
  lccdt_rd_state_type rd_state_q;   // read channel state
  logic               aw_held_q;    // address taken, waiting data
  logic               w_held_q;     // data taken, waiting address
  logic [ADDR_W-1:0]  aw_addr_q;    // held write address
  logic [7:0]         w_byte_q;     // held write byte
  logic               w_lane_q;     // held lane zero strobe
  logic [1:0]         bresp_q;      // write answer
  logic [DATA_W-1:0]  rdata_q;      // read data
  logic [1:0]         rresp_q;      // read answer

  logic [7:0]         cnt1_q;       // first stage counts
  logic [7:0]         phase_q;      // phase offsets
  logic [7:0]         cnt2_q;       // second stage counts
  logic [7:0]         ctrl_q;       // channel control
  logic [7:0]         duty_q;       // duty correction

  logic [2:0]         sync_pipe_q;  // pin synchroniser
  logic               sync_act_q;   // filtered sync level
  logic               dist_q;       // distribution clock level
  logic               dist_tick_q;  // distribution rising edge
  logic               channel_q;    // registered channel output

  // ****************************************
  // write channel decode
  // ****************************************
  logic              aw_take;       // address accepted now
  logic              w_take;        // data accepted now
  logic              wr_fire;       // both halves present
  logic [ADDR_W-1:0] wr_addr;       // address of this write
  logic [7:0]        wr_byte;       // byte of this write
  logic              wr_lane;       // lane zero enabled
  logic [9:0]        wr_idx;        // register index
  logic              wr_hit_cnt1;
  logic              wr_hit_phase;
  logic              wr_hit_cnt2;
  logic              wr_hit_ctrl;
  logic              wr_hit_duty;
  logic              wr_ok;         // writable register hit
  logic              wr_commit;     // store this cycle

  assign s_axi_awready = (wr_state_q == WR_IDLE) && !aw_held_q;
  assign s_axi_wready  = (wr_state_q == WR_IDLE) && !w_held_q;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign wr_fire       = (aw_held_q || aw_take) && (w_held_q || w_take);
  assign wr_addr       = aw_held_q ? aw_addr_q : s_axi_awaddr;
  assign wr_byte       = w_held_q ? w_byte_q : s_axi_wdata[7:0];
  assign wr_lane       = w_held_q ? w_lane_q : s_axi_wstrb[0];
  assign wr_idx        = wr_addr[ADDR_W-1:IDX_LSB];
  assign wr_hit_cnt1   = (wr_idx == IDX_CNT1);
  assign wr_hit_phase  = (wr_idx == IDX_PHASE);
  assign wr_hit_cnt2   = (wr_idx == IDX_CNT2);
  assign wr_hit_ctrl   = (wr_idx == IDX_CTRL);
  assign wr_hit_duty   = (wr_idx == IDX_DUTY);
  assign wr_ok         = wr_hit_cnt1 || wr_hit_phase || wr_hit_cnt2 ||
                         wr_hit_ctrl || wr_hit_duty;
  assign wr_commit     = wr_fire && wr_lane && wr_ok;

  // ****************************************
  // write channel state
  // ****************************************
  // collect address and data in either order, then answer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wr_state_q <= WR_IDLE;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
    end else begin
      case (wr_state_q)
        WR_IDLE: begin
          if (wr_fire) begin
            // both halves here: store and answer
            wr_state_q <= WR_RESP;
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            bresp_q    <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end else begin
            // keep whichever half arrived
            aw_held_q <= aw_held_q || aw_take;
            w_held_q  <= w_held_q || w_take;
          end
        end
        WR_RESP: begin
          // wait for the master to take the answer
          if (s_axi_bready) begin
            wr_state_q <= WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= WR_IDLE;
        end
      endcase
    end
  end

  // held halves of a split write
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aw_addr_q <= '0;
      w_byte_q  <= REG_RST;
      w_lane_q  <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_byte_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
    end
  end

  assign s_axi_bvalid = (wr_state_q == WR_RESP);
  assign s_axi_bresp  = bresp_q;

  // ****************************************
  // configuration registers
  // ****************************************
  // reserved bits are dropped so they read zero
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt1_q  <= REG_RST;
      phase_q <= REG_RST;
      cnt2_q  <= REG_RST;
      ctrl_q  <= REG_RST;
      duty_q  <= REG_RST;
    end else if (wr_commit) begin
      if (wr_hit_cnt1) begin
        cnt1_q <= wr_byte;             // R03
      end
      if (wr_hit_phase) begin
        phase_q <= wr_byte;            // R04
      end
      if (wr_hit_cnt2) begin
        cnt2_q <= wr_byte;             // R01 R02
      end
      if (wr_hit_ctrl) begin
        ctrl_q <= wr_byte & CTRL_MASK;
      end
      if (wr_hit_duty) begin
        duty_q <= wr_byte & DUTY_MASK; // R11
      end
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  logic [9:0] rd_idx;     // register index
  logic       rd_ok;      // mapped register
  logic [7:0] stat_byte;  // live status
  logic [7:0] rd_byte;    // selected register
  logic       ar_take;    // address accepted now

  assign rd_idx  = s_axi_araddr[ADDR_W-1:IDX_LSB];
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_ok   = (rd_idx == IDX_CNT1) || (rd_idx == IDX_PHASE) ||
                   (rd_idx == IDX_CNT2) || (rd_idx == IDX_CTRL) ||
                   (rd_idx == IDX_DUTY) || (rd_idx == IDX_STAT);

  // status: sync, output and stage levels
  always_comb begin
    stat_byte          = REG_RST;
    stat_byte[ST_SYNC] = sync_act_q;
    stat_byte[ST_OUT]  = channel_q;
    stat_byte[ST_S1]   = stage1_out;
    stat_byte[ST_S2]   = stage2_out;
  end

  assign rd_byte = (rd_idx == IDX_CNT1)  ? cnt1_q  :
                   (rd_idx == IDX_PHASE) ? phase_q :
                   (rd_idx == IDX_CNT2)  ? cnt2_q  :
                   (rd_idx == IDX_CTRL)  ? ctrl_q  :
                   (rd_idx == IDX_DUTY)  ? duty_q  :
                   (rd_idx == IDX_STAT)  ? stat_byte : REG_RST;

  // one read at a time, data registered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_state_q <= RD_IDLE;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
    end else begin
      case (rd_state_q)
        RD_IDLE: begin
          if (ar_take) begin
            rd_state_q <= RD_DATA;
            rdata_q    <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
            rresp_q    <= rd_ok ? RESP_OKAY : RESP_SLVERR;
          end
        end
        RD_DATA: begin
          // hold data until taken
          if (s_axi_rready) begin
            rd_state_q <= RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_arready = (rd_state_q == RD_IDLE);
  assign s_axi_rvalid  = (rd_state_q == RD_DATA);
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // ****************************************
  // chip sync input
  // ****************************************
  // three flops; level moves once the last two agree
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_pipe_q <= SYNC_IDLE;
      sync_act_q  <= 1'b0;
    end else begin
      sync_pipe_q <= {sync_pipe_q[1:0], sync_req_b};
      if (sync_pipe_q[1] == sync_pipe_q[2]) begin
        sync_act_q <= !sync_pipe_q[2];
      end
    end
  end

  logic hold;  // stages held at start level
  assign hold = sync_act_q && !ctrl_q[CTL_NOSYNC]; // R07 R13

  // ****************************************
  // distribution clock
  // ****************************************
  // half rate level with a pulse on each rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dist_q      <= 1'b0;
      dist_tick_q <= 1'b0;
    end else begin
      dist_q      <= !dist_q;
      dist_tick_q <= !dist_q;
    end
  end

  // ****************************************
  // cascaded divider stages
  // ****************************************
  lccdt_clk_type       clk_chain [NUM_STAGES+1]; // stage inputs and outputs
  lccdt_stage_cfg_type stage_cfg [NUM_STAGES];   // per stage settings

  assign clk_chain[0] = '{tick: dist_tick_q, level: dist_q};

  // first stage settings
  assign stage_cfg[0] = '{
    low_n:      cnt1_q[LOW_LSB+:NIB_W],   // R03
    high_n:     cnt1_q[HIGH_LSB+:NIB_W],  // R03
    phase:      phase_q[PH1_LSB+:NIB_W],  // R04
    start_high: ctrl_q[CTL_START1],       // R10
    bypass:     ctrl_q[CTL_BYP1]          // R06
  };

  // second stage settings
  assign stage_cfg[1] = '{
    low_n:      cnt2_q[LOW_LSB+:NIB_W],   // R01
    high_n:     cnt2_q[HIGH_LSB+:NIB_W],  // R02
    phase:      phase_q[PH2_LSB+:NIB_W],  // R04
    start_high: ctrl_q[CTL_START2],       // R09
    bypass:     ctrl_q[CTL_BYP2]          // R05
  };

  // each stage after the first is clocked by the one before, the first by the distribution clock
  genvar gi;
  generate
    for (gi = 0; gi < NUM_STAGES; gi++) begin : g_stage
      lccdt_divider u_div (
        .clock   (clock),
        .rst_b   (rst_b),
        .cfg     (stage_cfg[gi]),
        .hold    (hold),
        .clk_in  (clk_chain[gi]),    // R12
        .clk_out (clk_chain[gi+1])
      );
    end
  endgenerate

  assign stage1_out = clk_chain[1].level;
  assign stage2_out = clk_chain[NUM_STAGES].level;

  // ****************************************
  // duty correction and output
  // ****************************************
  logic duty_level;  // corrected second stage level

  lccdt_duty_fix u_duty (
    .clock     (clock),
    .rst_b     (rst_b),
    .enable    (!duty_q[DUTY_OFF]),   // R11
    .clk_in    (clk_chain[NUM_STAGES]),
    .out_level (duty_level)
  );

  // static high only with sync ignored
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      channel_q <= 1'b0;
    end else begin
      channel_q <= (ctrl_q[CTL_NOSYNC] && ctrl_q[CTL_FORCE]) || duty_level; // R08
    end
  end

  assign channel_out = channel_q;

endmodule // lccdt_top

// *** lccdt_assertions.sv ***
// checker: register bus handshake properties of the channel divider top
`timescale 1ns/100ps

module lccdt_assertions
  import lccdt_pkg::*;
(
  // clock and reset
  input logic              clock,
  input logic              rst_b,
  // bus handshakes watched
  input logic              s_axi_awvalid,
  input logic              s_axi_awready,
  input logic              s_axi_wvalid,
  input logic              s_axi_wready,
  input logic [1:0]        s_axi_bresp,
  input logic              s_axi_bvalid,
  input logic              s_axi_bready,
  input logic              s_axi_arvalid,
  input logic              s_axi_arready,
  input logic [DATA_W-1:0] s_axi_rdata,
  input logic              s_axi_rvalid,
  input logic              s_axi_rready
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer missing");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above register width");
endmodule // lccdt_assertions

bind lccdt_top lccdt_assertions u_chk (
  .clock(clock), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** test_lccdt_top.sv ***
// testbench: register access and divided waveforms of the channel divider
`timescale 1ns/100ps

module test_lccdt_top;
  import lccdt_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic              clock, rst_b, sync_req_b, s1, s2, ch;
  logic              awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr;
  logic [ADDR_W-1:0] aw, ar;
  logic [DATA_W-1:0] wd, rdat;
  logic [1:0]        bresp, rresp;
  logic [7:0]        c;
  int                n_fail, check_count, cyc, h, l;

  lccdt_top u_dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(aw), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ar), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .sync_req_b(sync_req_b), .stage1_out(s1), .stage2_out(s2),
    .channel_out(ch));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write: both halves offered together, answer checked
  task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
    aw <= {i, 2'h0}; wd <= {24'h0, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    forever begin
      @(posedge clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv && br) begin
        chk(bresp, e); br <= 1'b0; @(posedge clock); break;
      end
    end
  endtask

  // bus read: data and answer checked
  task automatic rd(input logic [9:0] i, input logic [7:0] d, input logic [1:0] e);
    ar <= {i, 2'h0}; arv <= 1'b1; rr <= 1'b1;
    forever begin
      @(posedge clock);
      if (arv && arr) arv <= 1'b0;
      if (rv && rr) begin
        chk(rdat, {24'h0, d}); chk(rresp, e); rr <= 1'b0; @(posedge clock); break;
      end
    end
  endtask

  function automatic logic pick(int s);
    return s == 0 ? s1 : s == 1 ? s2 : ch;
  endfunction

  // one full high phase then the low phase, in clocks; first period discarded
  task automatic meas(input int s);
    repeat (2) begin
      h = 0; l = 0;
      while (pick(s) !== 1'b0) @(posedge clock);
      while (pick(s) !== 1'b1) @(posedge clock);
      while (pick(s) === 1'b1) begin h++; @(posedge clock); end
      while (pick(s) === 1'b0) begin l++; @(posedge clock); end
    end
  endtask

  task automatic per(input int s, input int eh, input int el);
    meas(s); chk(h, eh); chk(l, el);
  endtask

  // output held at one level for 30 clocks
  task automatic hold(input int s, input logic v);
    int k;
    k = 0;
    repeat (30) begin @(posedge clock); if (pick(s) === v) k++; end
    chk(k, 30);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin clock = 1'b0; forever #4 clock = ~clock; end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin n_fail++; close_out; end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {awv, wv, br, arv, rr} = 5'h0; aw = '0; ar = '0; wd = '0;
    sync_req_b = 1'b1; rst_b = 1'b0; n_fail = 0; check_count = 0; cyc = 0;
    void'($urandom(32'hf3d955b9));
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 5; i++) rd(IDX_CNT1 + 10'(i), REG_RST, RESP_OKAY);
    for (int i = 0; i < 5; i++) begin
      c = 8'($urandom);
      wr(IDX_CNT1 + 10'(i), c, RESP_OKAY);
      rd(IDX_CNT1 + 10'(i), c & (i == 3 ? CTRL_MASK : i == 4 ? DUTY_MASK : 8'hff), RESP_OKAY);
    end
    rd(10'h000, 8'h00, RESP_SLVERR);
    wr(IDX_STAT, 8'hff, RESP_SLVERR);
    wr(IDX_DUTY, 8'h01, RESP_OKAY); wr(IDX_CTRL, 8'h00, RESP_OKAY);
    wr(IDX_PHASE, 8'h00, RESP_OKAY); wr(IDX_CNT1, 8'h00, RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      c = k == 0 ? 8'hf0 : 8'($urandom);
      wr(IDX_CNT2, c, RESP_OKAY);
      per(1, (c[3:0] + 1) * 4, (c[7:4] + 1) * 4);
      per(2, (c[3:0] + 1) * 4, (c[7:4] + 1) * 4);
    end
    wr(IDX_CTRL, 8'h10, RESP_OKAY);
    per(1, (c[3:0] + 1) * 2, (c[7:4] + 1) * 2);
    wr(IDX_CTRL, 8'h20, RESP_OKAY); wr(IDX_CNT1, 8'h21, RESP_OKAY);
    per(1, 4, 6);
    wr(IDX_CTRL, 8'h00, RESP_OKAY); wr(IDX_CNT1, 8'h00, RESP_OKAY);
    wr(IDX_CNT2, 8'h50, RESP_OKAY); wr(IDX_DUTY, 8'h00, RESP_OKAY);
    meas(2);
    chk(h >= 13 && h <= 15, 1);
    chk(h + l, 28);
    wr(IDX_CTRL, 8'h0c, RESP_OKAY);
    repeat (10) @(posedge clock);
    hold(2, 1'b1);
    // force alone, sync obeyed: output keeps toggling
    wr(IDX_CTRL, 8'h04, RESP_OKAY);
    meas(2);
    chk(h + l, 28);
    for (int s = 0; s < 4; s += 3) begin
      wr(IDX_CTRL, 8'(s), RESP_OKAY);
      sync_req_b <= 1'b0;
      repeat (10) @(posedge clock);
      hold(0, s[0]);
      hold(1, s[1]);
      sync_req_b <= 1'b1;
      per(0, 2, 2);
    end
    // random first stage phase: release delay grows by two clocks per step
    c = 8'($urandom) & 8'h0f;
    wr(IDX_PHASE, c, RESP_OKAY);
    wr(IDX_CTRL, 8'h00, RESP_OKAY);
    sync_req_b <= 1'b0;
    repeat (10) @(posedge clock);
    sync_req_b <= 1'b1;
    h = 0;
    while (s1 !== 1'b1 && h < 99) begin h++; @(posedge clock); end
    chk(h >= 6 + 2 * c && h <= 7 + 2 * c, 1);
    wr(IDX_CTRL, 8'h08, RESP_OKAY);
    sync_req_b <= 1'b0;
    per(0, 2, 2);
    sync_req_b <= 1'b1;
    close_out;
  end
endmodule // test_lccdt_top
